// *** logic/dam_addr_mux.sv ***
// address decode and row/column multiplexing for four chip selects
// assumes same-clock request and write inputs; configuration held stable between requests
`timescale 1ns/100ps
`default_nettype none
module dam_addr_mux (
	input wire logic core_clk,  // controller clock
	input wire logic rst,  // synchronous reset
	input wire dam_pkg::dam_req_type req,  // request from bus master
	input wire dam_pkg::dam_wr_type wr,  // write data for lanes
	input wire dam_pkg::dam_cs_cfg_type [dam_pkg::NUM_CS-1:0] cs_cfg,  // per cs setup
	input wire logic [1:0] interleave_control_field,  // cs interleave mode
	input wire logic bus_32,  // 1: 32-bit data bus
	output logic [dam_pkg::NUM_CS-1:0] bank_chip_select_n,  // active-low cs
	output logic [dam_pkg::MA_W-1:0] memory_address_bus,  // muxed row/column
	output logic [dam_pkg::BA_W-1:0] logical_bank_select,  // bank bits
	output logic addr_valid,  // address outputs valid, pulse
	output logic mem_select_err,  // no cs matched, pulse
	output logic [0:dam_pkg::DATA_W-1] memory_data_lines,  // lane data
	output logic [0:dam_pkg::LANES-1] byte_lane_mask,  // lane masks
	output logic [0:dam_pkg::LANES-1] byte_lane_strobe_oe  // lane strobe enables
);
	typedef struct packed {
		logic valid;
		logic err;
		logic [dam_pkg::NUM_CS-1:0] cs_n;
		logic [dam_pkg::MA_W-1:0] ma;
		logic [dam_pkg::BA_W-1:0] ba;
		logic [0:dam_pkg::DATA_W-1] dq;
		logic [0:dam_pkg::LANES-1] mask;
		logic [0:dam_pkg::LANES-1] dqs_oe;
	} dam_state_type;

	dam_state_type state_q;
	dam_state_type state_d;

	logic [dam_pkg::NUM_CS-1:0] hit;
	logic [0:dam_pkg::DATA_W-1] lane_data;
	logic [0:dam_pkg::LANES-1] lane_mask;
	logic [0:dam_pkg::LANES-1] lane_strobe_oe;

	dam_cs_match u_match (
		.cs_cfg(cs_cfg),
		.addr_hi(req.addr[dam_pkg::RANGE_LSB +: dam_pkg::RANGE_W]),
		.hit(hit)
	);

	dam_lane_map u_lanes (
		.wr(wr),
		.lane_data(lane_data),
		.lane_mask(lane_mask),
		.lane_strobe_oe(lane_strobe_oe)
	);

	// decode signals
	logic [1:0] first_cs;
	logic any_hit;
	dam_pkg::dam_geom_type geom;
	logic [4:0] col_n;
	logic [4:0] bank_n;
	logic [4:0] row_n;
	logic [4:0] col_lsb;
	logic [4:0] bank_lsb;
	logic [4:0] sel_lsb;
	logic [4:0] row_lsb;
	logic [4:0] ilv_n;
	logic ilv_on;
	logic [1:0] grp_base;
	logic [1:0] sel_val;
	logic [1:0] cs_idx;
	logic [dam_pkg::ADDR_W-1:0] col_raw;
	logic [dam_pkg::ADDR_W-1:0] bank_raw;
	logic [dam_pkg::ADDR_W-1:0] row_raw;
	logic [dam_pkg::ADDR_W-1:0] sel_raw;
	logic [dam_pkg::MA_W-1:0] ma_col;

	always_comb begin
		// lowest matching cs wins if ranges overlap, so only one cs fires
		first_cs = 2'h0;
		for (int k = dam_pkg::NUM_CS - 1; k >= 0; k--) begin
			if (hit[k]) begin
				first_cs = k[1:0];
			end
		end
		any_hit = |hit;
		// group members share one size, so first match geometry serves all
		geom = cs_cfg[first_cs].geom;
		col_n = dam_pkg::col_bits(geom);
		bank_n = dam_pkg::bank_bits(geom);
		row_n = dam_pkg::row_bits(geom);
		// interleave mode picks the group
		ilv_on = 1'b0;
		grp_base = 2'h0;
		ilv_n = 5'h00;
		case (interleave_control_field)
			dam_pkg::INTLV_CS01: begin
				ilv_on = (first_cs == 2'h0) || (first_cs == 2'h1);
				ilv_n = ilv_on ? 5'h01 : 5'h00;
			end
			dam_pkg::INTLV_CS23: begin
				ilv_on = (first_cs == 2'h2) || (first_cs == 2'h3);
				grp_base = 2'h2;
				ilv_n = ilv_on ? 5'h01 : 5'h00;
			end
			dam_pkg::INTLV_ALL: begin
				ilv_on = 1'b1;
				ilv_n = 5'h02;
			end
			default: begin
				ilv_on = 1'b0;
			end
		endcase
		// low bits below the column are byte offset within the bus width
		col_lsb = bus_32 ? dam_pkg::COL_LSB_32 : dam_pkg::COL_LSB_64;
		bank_lsb = col_lsb + col_n;
		sel_lsb = bank_lsb + bank_n;  // select bits right above bank
		row_lsb = sel_lsb + ilv_n;  // row moves up past select bits
		col_raw = (req.addr >> col_lsb) & dam_pkg::low_mask(col_n);
		bank_raw = (req.addr >> bank_lsb) & dam_pkg::low_mask(bank_n);
		sel_raw = (req.addr >> sel_lsb) & dam_pkg::low_mask(ilv_n);
		row_raw = (req.addr >> row_lsb) & dam_pkg::low_mask(row_n);
		sel_val = sel_raw[1:0];
		cs_idx = ilv_on ? (grp_base | sel_val) : first_cs;
		// column skips line 10, which carries the auto-precharge flag
		ma_col = dam_pkg::MA_RESET;
		ma_col[9:0] = col_raw[9:0];
		ma_col[dam_pkg::AP_BIT] = req.auto_pre;
		ma_col[11] = col_raw[10];
	end

	always_comb begin
		state_d = state_q;
		state_d.valid = 1'b0;
		state_d.err = 1'b0;
		state_d.cs_n = dam_pkg::CS_N_IDLE;
		if (req.valid) begin
			if (!any_hit) begin
				// no enabled range holds the address: flag, leave memory untouched
				state_d.err = 1'b1;
			end else begin
				state_d.valid = 1'b1;
				state_d.cs_n[cs_idx] = 1'b0;  // one of four cs outputs
				// line 15 msb, line 0 lsb; row or column per phase
				state_d.ma = req.col_phase ? ma_col : row_raw[dam_pkg::MA_W-1:0];
				state_d.ba = bank_raw[dam_pkg::BA_W-1:0];
			end
		end
		state_d.dq = lane_data;
		state_d.mask = lane_mask;
		state_d.dqs_oe = lane_strobe_oe;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= '{valid: 1'b0, err: 1'b0, cs_n: dam_pkg::CS_N_IDLE, ma: dam_pkg::MA_RESET,
				ba: dam_pkg::BA_RESET, dq: '0, mask: '1, dqs_oe: '0};
		end else begin
			state_q <= state_d;
		end
	end

	assign bank_chip_select_n = state_q.cs_n;
	assign memory_address_bus = state_q.ma;
	assign logical_bank_select = state_q.ba;
	assign addr_valid = state_q.valid;
	assign mem_select_err = state_q.err;
	assign memory_data_lines = state_q.dq;
	assign byte_lane_mask = state_q.mask;
	assign byte_lane_strobe_oe = state_q.dqs_oe;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_err_on_miss: assert property (req.valid && !(|hit) |=> mem_select_err && !addr_valid)
		else $error("select error missing for unmatched address");
	a_err_no_cs: assert property (mem_select_err |-> bank_chip_select_n == 4'hf)
		else $error("chip select asserted with select error");
	a_one_cs: assert property (addr_valid |-> $onehot(~bank_chip_select_n))
		else $error("not exactly one chip select on valid access");
	a_cs_enabled: assert property (req.valid && (|hit) && interleave_control_field == 2'h0
		|=> !bank_chip_select_n[$past(first_cs)] && $past(cs_cfg[first_cs].enable))
		else $error("selected chip select was not the enabled match");
	a_ap_on_line10: assert property (req.valid && (|hit) && req.col_phase
		|=> memory_address_bus[10] == $past(req.auto_pre))
		else $error("line 10 does not carry auto-precharge");
	a_two_bank_bits: assert property (req.valid && (|hit) && !geom.bank3
		|=> logical_bank_select[2] == 1'b0)
		else $error("third bank bit set on two-bank geometry");
	a_lane_mask: assert property (wr.valid |=> byte_lane_mask == ~$past(wr.byte_en)
		&& byte_lane_strobe_oe == 8'hff)
		else $error("lane mask does not follow byte enables");
	a_lane0_data: assert property (wr.valid |=> memory_data_lines[0:7] == $past(wr.data[0:7]))
		else $error("lane 0 data not on data lines 0 to 7");
	a_ignore_low: assert property (req.valid && (|hit) && !bus_32 && !req.col_phase
		&& interleave_control_field == 2'h0 && cs_cfg[first_cs].geom == 6'h00
		|=> memory_address_bus == {4'h0, $past(req.addr[24:13])})
		else $error("row bits misplaced for 12x8x2 on 64-bit bus");
	a_ilv_pair: assert property (req.valid && (|hit) && interleave_control_field == 2'h1
		&& first_cs < 2'h2 |=> bank_chip_select_n[3:2] == 2'h3)
		else $error("pair interleave left its group");
endmodule // dam_addr_mux
`default_nettype wire

// *** logic/dam_pkg.sv ***
// constants, carriers and geometry helpers for the ddr address decode and mux block
// assumes a single controller clock domain and a synchronous active-high reset
//
// Functional notes
// - byte lane 0 is the msb lane: mask 0, strobe 0, data 0..7; lane 7 last.
// - row and column share a 16-bit address bus; three bank select outputs.
// - per bank: 12 to 16 row bits, 2 or 3 bank bits, 8 to 11 column bits.
// - address outside every enabled chip select range raises a select error instead.
// - assert the one chip select whose start/end range holds the address.
// - each chip select range decodes on its own; gaps are allowed.
// - address line 15 is the msb and line 0 the lsb.
// - line 10 carries auto-precharge on column phase; column bits skip it.
// - 64-bit bus, no interleave: drop bits 33..35, then column, bank, row upward.
// - 32-bit bus, no interleave: drop bits 34..35, then column, bank, row upward.
// - interleave field selects cs0/1 pair, cs2/3 pair or all four.
// - interleave takes one extra address bit for two selects, two for four.
// - the select bits sit right above the bank bits; row moves up.
// - four chip select outputs, one per physical bank.
package dam_pkg;

	localparam int unsigned NUM_CS = 4;
	localparam int unsigned ADDR_W = 36;
	localparam int unsigned RANGE_W = 12;
	localparam int unsigned RANGE_LSB = 24;
	localparam int unsigned MA_W = 16;
	localparam int unsigned BA_W = 3;
	localparam int unsigned LANES = 8;
	localparam int unsigned DATA_W = 64;

	localparam logic [1:0] INTLV_NONE = 2'h0;
	localparam logic [1:0] INTLV_CS01 = 2'h1;
	localparam logic [1:0] INTLV_CS23 = 2'h2;
	localparam logic [1:0] INTLV_ALL = 2'h3;

	localparam logic [4:0] ROW_MIN = 5'h0c;
	localparam logic [4:0] COL_MIN = 5'h08;
	localparam logic [4:0] BANK_MIN = 5'h02;
	localparam logic [4:0] COL_LSB_64 = 5'h03;
	localparam logic [4:0] COL_LSB_32 = 5'h02;
	localparam int unsigned AP_BIT = 10;

	localparam logic [3:0] CS_N_IDLE = 4'hf;
	localparam logic [15:0] MA_RESET = 16'h0000;
	localparam logic [2:0] BA_RESET = 3'h0;

	typedef struct packed {
		logic [2:0] row_code;  // rows = 12 + code, 0..4
		logic bank3;           // 1: three bank bits
		logic [1:0] col_code;  // cols = 8 + code
	} dam_geom_type;

	typedef struct packed {
		logic enable;
		logic [RANGE_W-1:0] start_addr;
		logic [RANGE_W-1:0] end_addr;
		dam_geom_type geom;
	} dam_cs_cfg_type;

	typedef struct packed {
		logic valid;
		logic col_phase;   // 0: activate (row), 1: read/write (column)
		logic auto_pre;
		logic [ADDR_W-1:0] addr;  // addr[35] is master bit 0
	} dam_req_type;

	typedef struct packed {
		logic valid;
		logic [0:DATA_W-1] data;
		logic [0:LANES-1] byte_en;
	} dam_wr_type;

	function automatic logic [ADDR_W-1:0] low_mask(input logic [4:0] n);
		low_mask = (36'h1 << n) - 36'h1;
	endfunction

	function automatic logic [4:0] row_bits(input dam_geom_type g);
		row_bits = ROW_MIN + {2'h0, g.row_code};
	endfunction

	function automatic logic [4:0] col_bits(input dam_geom_type g);
		col_bits = COL_MIN + {3'h0, g.col_code};
	endfunction

	function automatic logic [4:0] bank_bits(input dam_geom_type g);
		bank_bits = BANK_MIN + {4'h0, g.bank3};
	endfunction

endpackage

// *** logic/dam_cs_match.sv ***
// per chip select range comparators
// assumes range fields are the upper address bits, compared inclusively
`timescale 1ns/100ps
`default_nettype none
module dam_cs_match (
	input wire dam_pkg::dam_cs_cfg_type [dam_pkg::NUM_CS-1:0] cs_cfg,  // range and enable per cs
	input wire logic [dam_pkg::RANGE_W-1:0] addr_hi,  // upper request address bits
	output logic [dam_pkg::NUM_CS-1:0] hit  // one bit per matching cs
);
	genvar i;
	generate
		for (i = 0; i < dam_pkg::NUM_CS; i++) begin : g_cs
			// independent compare per cs, gaps between ranges allowed
			assign hit[i] = cs_cfg[i].enable && (addr_hi >= cs_cfg[i].start_addr) &&
				(addr_hi <= cs_cfg[i].end_addr);
		end
	endgenerate
endmodule // dam_cs_match
`default_nettype wire

// *** logic/dam_lane_map.sv ***
// byte lane to mask, strobe and data mapping, lane 0 most significant
// assumes byte enables active high; mask is their inverse
`timescale 1ns/100ps
`default_nettype none
module dam_lane_map (
	input wire dam_pkg::dam_wr_type wr,  // write data and enables
	output logic [0:dam_pkg::DATA_W-1] lane_data,  // data per lane
	output logic [0:dam_pkg::LANES-1] lane_mask,  // high masks a byte
	output logic [0:dam_pkg::LANES-1] lane_strobe_oe  // strobe driven
);
	genvar i;
	generate
		for (i = 0; i < dam_pkg::LANES; i++) begin : g_lane
			// lane i owns mask i, strobe i, data 8i..8i+7
			assign lane_data[8*i +: 8] = wr.valid ? wr.data[8*i +: 8] : 8'h00;
			assign lane_mask[i] = wr.valid ? ~wr.byte_en[i] : 1'b1;
			assign lane_strobe_oe[i] = wr.valid;
		end
	endgenerate
endmodule // dam_lane_map
`default_nettype wire

// *** tb/dam_sdram_model.sv ***
// stand-in for the sdram ranks behind the controller: counts selects per rank
// assumes active-low rank selects sampled on the controller clock
`timescale 1ns/100ps
`default_nettype none
module dam_sdram_model (
	input wire logic core_clk, // controller clock
	input wire logic rst, // synchronous reset
	input wire logic [3:0] bank_chip_select_n, // rank selects
	output logic [3:0][7:0] sel_cnt, // selects seen per rank
	output logic multi_sel // two ranks selected at once
);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sel_cnt <= '0;
			multi_sel <= 1'b0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!bank_chip_select_n[i]) sel_cnt[i] <= sel_cnt[i] + 8'h01;
			end
			// a rank pair driven together would corrupt the shared bus
			if ($countones(~bank_chip_select_n) > 1) multi_sel <= 1'b1;
		end
	end
endmodule // dam_sdram_model
`default_nettype wire

// *** tb/tb_dam_addr_mux.sv ***
// self-checking bench for the address decode and mux block
// assumes the rank model beside it; all inputs move 1 ns after the clock edge
`timescale 1ns/100ps
`default_nettype none
module tb_dam_addr_mux;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	dam_pkg::dam_req_type req = '0;
	dam_pkg::dam_wr_type wr = '0;
	dam_pkg::dam_cs_cfg_type [3:0] cs_cfg = '0;
	logic [1:0] interleave_control_field = 2'h0;
	logic bus_32 = 1'b0;
	logic [3:0] bank_chip_select_n;
	logic [15:0] memory_address_bus;
	logic [2:0] logical_bank_select;
	logic addr_valid, mem_select_err, multi_sel;
	logic [0:63] memory_data_lines;
	logic [0:7] byte_lane_mask, byte_lane_strobe_oe;
	logic [3:0][7:0] sel_cnt;
	logic [15:0] exp_ma = 16'h0000;
	logic [2:0] exp_ba = 3'h0;
	int error_cnt = 0, n_checks = 0, L = 3, nc, nb, nr, ns = 0;
	int exp_cnt [4] = '{0, 0, 0, 0};
	always #25 core_clk = ~core_clk;
	dam_addr_mux u_dam_addr_mux (.core_clk, .rst, .req, .wr, .cs_cfg, .interleave_control_field, .bus_32,
		.bank_chip_select_n, .memory_address_bus, .logical_bank_select, .addr_valid, .mem_select_err,
		.memory_data_lines, .byte_lane_mask, .byte_lane_strobe_oe);
	dam_sdram_model u_dam_sdram_model (.core_clk, .rst, .bank_chip_select_n, .sel_cnt, .multi_sel);
	task automatic results();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [63:0] fld(input logic [35:0] a, input int lsb, input int n);
		return (64'(a) >> lsb) & ((64'h1 << n) - 64'h1);
	endfunction
	task automatic geo(input int r, input int c, input int b);
		for (int i = 0; i < 4; i++) cs_cfg[i].geom = {3'(r - 12), 1'(b - 2), 2'(c - 8)};
		nr = r;
		nc = c;
		nb = b;
	endtask
	task automatic rng(input int i, input logic en, input logic [11:0] s, input logic [11:0] e);
		cs_cfg[i].enable = en;
		cs_cfg[i].start_addr = s;
		cs_cfg[i].end_addr = e;
	endtask
	// called 1 ns after an edge; leaves the request up so calls run back to back
	task automatic acc(input logic [35:0] a, input logic ph, input logic ap, input logic [3:0] ecs);
		logic [63:0] col, row, bk;
		req = {1'b1, ph, ap, a};
		@(posedge core_clk);
		#1;
		col = fld(a, L, nc);
		bk = fld(a, L + nc, nb);
		row = fld(a, L + nc + nb + ns, nr);
		if (ecs != 4'hf) begin
			exp_ma = ph ? {4'h0, col[10], ap, col[9:0]} : row[15:0];
			exp_ba = bk[2:0];
			for (int i = 0; i < 4; i++) if (!ecs[i]) exp_cnt[i]++;
		end
		chk(bank_chip_select_n, ecs);
		chk(mem_select_err, ecs == 4'hf);
		chk(addr_valid, ecs != 4'hf);
		chk(memory_address_bus, exp_ma);
		chk(logical_bank_select, exp_ba);
	endtask
	task automatic idle();
		req.valid = 1'b0;
		@(posedge core_clk);
		#1;
		chk(bank_chip_select_n, 4'hf);
		chk(addr_valid | mem_select_err, 1'b0);
	endtask
	initial begin
		#200000;
		error_cnt++;
		results();
	end
	initial begin
		repeat (4) @(posedge core_clk);
		#1 rst = 1'b0;
		chk(bank_chip_select_n, 4'hf);
		chk(byte_lane_mask, 8'hff);
		chk(byte_lane_strobe_oe, 8'h00);
		@(posedge core_clk);
		#1;
		rng(0, 1'b1, 12'h000, 12'h000);
		rng(1, 1'b1, 12'h001, 12'h001);
		rng(2, 1'b0, 12'h002, 12'h002);
		rng(3, 1'b1, 12'h004, 12'h005);
		// 12x8x2, 14x9x3, 16x11x3 on both bus widths; never 16-bit mode
		for (int g = 0; g < 3; g++) begin
			for (int w = 0; w < 2; w++) begin
				geo(12 + 2 * g, 8 + g + (g == 2), 2 + (g > 0));
				bus_32 = w[0];
				L = 3 - w;
				acc({12'h001, 24'hd3a5c7}, 1'b0, 1'b0, 4'hd);
				acc({12'h001, 24'hd3a5c7}, 1'b1, w[0], 4'hd);
				idle();
			end
		end
		acc({12'h004, 24'h000000}, 1'b0, 1'b0, 4'h7);
		acc({12'h002, 24'h123456}, 1'b0, 1'b0, 4'hf);
		acc({12'h003, 24'h654321}, 1'b0, 1'b0, 4'hf);
		acc({12'h005, 24'hffffff}, 1'b0, 1'b0, 4'h7);
		idle();
		rng(0, 1'b1, 12'h000, 12'h001);
		rng(1, 1'b1, 12'h000, 12'h001);
		rng(2, 1'b1, 12'h002, 12'h003);
		rng(3, 1'b1, 12'h002, 12'h003);
		for (int m = 1; m < 4; m++) begin
			interleave_control_field = 2'(m);
			ns = (m == 3) ? 2 : 1;
			for (int k = 0; k < 4; k++) begin
				acc({(m == 2) ? 12'h002 : 12'h001, 24'h0} | (36'(k) << (L + nc + nb)), 1'b0, 1'b0,
					~(4'h1 << (((m == 2) ? 2 : 0) | (k & ((m == 3) ? 3 : 1)))));
			end
			idle();
		end
		wr = {1'b1, 64'h8877665544332211, 8'hf0};
		@(posedge core_clk);
		#1 wr.valid = 1'b0;
		chk(memory_data_lines, 64'h8877665544332211);
		chk(memory_data_lines[0:7], 8'h88);
		chk(byte_lane_mask, 8'h0f);
		chk(byte_lane_strobe_oe, 8'hff);
		@(posedge core_clk);
		#1;
		chk(byte_lane_mask, 8'hff);
		chk(byte_lane_strobe_oe, 8'h00);
		chk(memory_data_lines, 64'h0);
		for (int i = 0; i < 4; i++) chk(sel_cnt[i], exp_cnt[i]);
		chk(multi_sel, 1'b0);
		results();
	end
endmodule // tb_dam_addr_mux
`default_nettype wire
